// File: pcs_pkg.sv
// Package of constants and types for the program counter, return stack and indirect addressing.
// Behaviour
// - Program counter is 13 bits; low byte readable and writable.
// - Any reset clears the whole program counter.
// - Counter bits 12..8 not directly accessible; set by latch, jump target, stack or vector. The bus OFF_PC register reads them, but no bus write reaches them.
// - Writing the low counter byte copies latch bits 4..0 into counter bits 12..8.
// - Call or jump takes latch bits 4..3; lower bits come from instruction.
// - Return stack has eight 13-bit entries; pointer not visible.
// - Call or interrupt branch pushes the program counter.
// - Return, return with literal and return from interrupt pop into counter.
// - Push and pop leave the high-bits latch unchanged.
// - Stack is circular; ninth push overwrites the first.
// - No overflow or underflow flag exists.
// - Indirect data port has no storage; accesses go to pointed location.
// - Indirect read that selects the indirect port itself returns zero.
// - Indirect write that selects the indirect port itself stores nothing.
// - Indirect address is 9 bits from pointer and bank pointer bit.
package pcs_pkg;

    localparam int PC_W = 13;
    localparam int LATCH_W = 5;
    localparam int DEPTH = 8;
    localparam int SP_W = 3;
    localparam int DADDR_W = 9;
    localparam int JUMP_W = 11;

    // Register byte addresses on the AXI4-Lite slave.
    localparam logic [7:0] OFF_LOW = 8'h00;
    localparam logic [7:0] OFF_LATCH = 8'h04;
    localparam logic [7:0] OFF_PTR = 8'h08;
    localparam logic [7:0] OFF_BANK = 8'h0C;
    localparam logic [7:0] OFF_PC = 8'h10;

    // Low seven bits of the indirect data port's own file address.
    localparam logic [6:0] INDIRECT_PORT_ADDR = 7'h00;

    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // Stack operation chosen by the sequencer.
    typedef enum logic [1:0] {
        PCS_STK_NONE,
        PCS_STK_PUSH,
        PCS_STK_POP
    } pcs_stk_op_t;

endpackage : pcs_pkg

// File: pcs_return_stack.sv
// Circular eight-entry hardware return stack.
module pcs_return_stack
    import pcs_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire pcs_pkg::pcs_stk_op_t op,
    input wire logic [pcs_pkg::PC_W-1:0] push_value,
    output logic [pcs_pkg::PC_W-1:0] top_value
);
    import pcs_pkg::*;

    typedef struct packed {
        logic [DEPTH-1:0][PC_W-1:0] mem;
        logic [SP_W-1:0] sp;
    } pcs_stk_state_t;

    pcs_stk_state_t st_r;
    pcs_stk_state_t st_nxt;

    // The entry just below the pointer is the top of stack.
    assign top_value = st_r.mem[st_r.sp - 3'h1];

    // Next-state logic for pushes and pops.
    always_comb
    begin
        st_nxt = st_r;
        unique case (op)
            PCS_STK_PUSH:
            begin
                st_nxt.mem[st_r.sp] = push_value;
                st_nxt.sp = st_r.sp + 3'h1;
            end
            PCS_STK_POP:
            begin
                st_nxt.sp = st_r.sp - 3'h1;
            end
            default:
            begin
                st_nxt = st_r;
            end
        endcase
    end

    // State register; pointer stays internal.
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            st_r <= '0;
        end
        else
        begin
            st_r <= st_nxt;
        end
    end

endmodule : pcs_return_stack

// File: pcs_program_counter.sv
// Program counter, return stack control, indirect addressing and AXI4-Lite registers.
//
// Design decisions made here: the register addresses and the AXI4-Lite slave port.
module pcs_program_counter
    import pcs_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    // Sequencing requests from the instruction decoder.
    input wire logic step,
    input wire logic low_write,
    input wire logic [7:0] low_wdata,
    input wire logic latch_write,
    input wire logic [pcs_pkg::LATCH_W-1:0] latch_wdata,
    input wire logic jump,
    input wire logic call,
    input wire logic [pcs_pkg::JUMP_W-1:0] jump_target,
    input wire logic irq_branch,
    input wire logic [pcs_pkg::PC_W-1:0] irq_vector,
    input wire logic ret,
    input wire logic ptr_write,
    input wire logic [7:0] ptr_wdata,
    input wire logic bank_pointer_bit,
    // Indirect access from the data path.
    input wire logic ind_rd,
    input wire logic ind_wr,
    input wire logic [7:0] ind_wdata,
    output logic [pcs_pkg::DADDR_W-1:0] mem_addr,
    output logic mem_we,
    output logic [7:0] mem_wdata,
    input wire logic [7:0] mem_rdata,
    output logic [7:0] ind_rdata,
    output logic [pcs_pkg::PC_W-1:0] pc,
    output logic [pcs_pkg::LATCH_W-1:0] program_counter_high_latch,
    output logic [7:0] indirect_pointer,
    // AXI4-Lite slave.
    input wire logic [7:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    input wire logic [7:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready
);
    import pcs_pkg::*;

    ////////////////////////////////////////////////////////////////////////////////
    // State.

    // All state of the block except the return stack, registered as one word.
    typedef struct packed {
        logic [PC_W-1:0] pc;
        logic [LATCH_W-1:0] latch;
        logic [7:0] ptr;
        logic [7:0] ind_rdata;
        logic aw_got;
        logic [7:0] aw_addr;
        logic w_got;
        logic [31:0] w_data;
        logic w_lane0;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } pcs_state_t;

    pcs_state_t st_r;
    pcs_state_t st_nxt;
    // Combinational helpers shared by the sections below.
    pcs_stk_op_t stk_op;
    logic [PC_W-1:0] stk_top;
    logic [PC_W-1:0] push_value;
    logic [DADDR_W-1:0] ind_addr;
    logic ind_self;
    logic bus_wr;
    logic [7:0] bus_wr_addr;

    ////////////////////////////////////////////////////////////////////////////////
    // Return stack.

    pcs_return_stack u_stack (
        .aclk(aclk),
        .aresetn(aresetn),
        .op(stk_op),
        .push_value(push_value),
        .top_value(stk_top)
    );

    // Choose the stack operation; the return address is the next instruction.
    // A call pushes the address after itself, while an interrupt branch pushes
    // the counter unchanged so that the interrupted instruction is not skipped.
    // When a push and a pop are asked for in one cycle the push wins, so the
    // caller's return address is never lost; the counter then follows ret, or irq_vector when the push is an interrupt branch.
    always_comb
    begin
        stk_op = PCS_STK_NONE;
        push_value = st_r.pc + 13'h0001;
        if (call || irq_branch)
        begin
            stk_op = PCS_STK_PUSH;
            if (irq_branch)
            begin
                push_value = st_r.pc;
            end
        end
        else if (ret)
        begin
            stk_op = PCS_STK_POP;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Indirect addressing.

    assign ind_addr = {bank_pointer_bit, st_r.ptr};
    // The port answers to its own low seven address bits in every bank, so a
    // pointer that aims back at the port can never reach real storage.
    assign ind_self = (st_r.ptr[6:0] == INDIRECT_PORT_ADDR);

    // No storage here; the pointed location is accessed.
    assign mem_addr = ind_addr;
    assign mem_we = ind_wr && !ind_self;
    assign mem_wdata = ind_wdata;
    // Read data sits in a flop and stands until the next indirect read.
    assign ind_rdata = st_r.ind_rdata;

    ////////////////////////////////////////////////////////////////////////////////
    // Outputs.

    assign pc = st_r.pc;
    assign program_counter_high_latch = st_r.latch;
    assign indirect_pointer = st_r.ptr;
    // Each write channel is refused once its item is held, and both stay
    // refused while the response waits, so one write at most is in flight.
    assign awready = !st_r.aw_got && !st_r.bvalid;
    assign wready = !st_r.w_got && !st_r.bvalid;
    assign bvalid = st_r.bvalid;
    assign bresp = st_r.bresp;
    // A new read is refused while the previous answer still waits.
    assign arready = !st_r.rvalid;
    assign rvalid = st_r.rvalid;
    assign rdata = st_r.rdata;
    assign rresp = st_r.rresp;

    // A bus write completes once both address and data are held.
    // A core write in the same cycle takes the register first; the bus word is then dropped.
    assign bus_wr = st_r.aw_got && st_r.w_got && !st_r.bvalid;
    assign bus_wr_addr = st_r.aw_addr;

    ////////////////////////////////////////////////////////////////////////////////
    // Next-state logic.

    always_comb
    begin
        // Hold every field unless a source below moves it.
        st_nxt = st_r;

        // Sequencer; the core ports other than step have priority over the bus.
        // Priority runs interrupt, return, call or jump, low byte write,
        // bus low byte write, then step, so one source at most moves the counter.
        if (irq_branch)
        begin
            st_nxt.pc = irq_vector;
        end
        else if (ret)
        begin
            st_nxt.pc = stk_top;
        end
        else if (call || jump)
        begin
            st_nxt.pc = {st_r.latch[4:3], jump_target};
        end
        else if (low_write)
        begin
            // All 13 bits change together.
            // No carry reaches the latch here; software moves it across pages.
            st_nxt.pc = {st_r.latch, low_wdata};
        end
        else if (bus_wr && bus_wr_addr == OFF_LOW && st_r.w_lane0)
        begin
            // Bus write to low byte also loads latch bits.
            st_nxt.pc = {st_r.latch, st_r.w_data[7:0]};
        end
        else if (step)
        begin
            // Plain advance; the counter wraps at the top of its 13-bit space.
            st_nxt.pc = st_r.pc + 13'h0001;
        end

        // Latch is the only writable register feeding the high bits.
        // A core write in the same cycle beats a bus write to the latch.
        if (latch_write)
        begin
            st_nxt.latch = latch_wdata;
        end
        else if (bus_wr && bus_wr_addr == OFF_LATCH && st_r.w_lane0)
        begin
            st_nxt.latch = st_r.w_data[LATCH_W-1:0];
        end

        // Pointer register; a core write in the same cycle beats the bus.
        if (ptr_write)
        begin
            st_nxt.ptr = ptr_wdata;
        end
        else if (bus_wr && bus_wr_addr == OFF_PTR && st_r.w_lane0)
        begin
            st_nxt.ptr = st_r.w_data[7:0];
        end

        // Self-selected read gives zero.
        // Data memory answers in the same cycle, so the byte is captured now.
        if (ind_rd)
        begin
            st_nxt.ind_rdata = ind_self ? 8'h00 : mem_rdata;
        end

        // Write address and data channels, taken in either order.
        if (awvalid && awready)
        begin
            st_nxt.aw_got = 1'b1;
            st_nxt.aw_addr = {awaddr[7:2], 2'b00};
        end
        if (wvalid && wready)
        begin
            st_nxt.w_got = 1'b1;
            st_nxt.w_data = wdata;
            st_nxt.w_lane0 = wstrb[0];
        end
        // Both halves held: the word is applied above and the response rises.
        if (bus_wr)
        begin
            st_nxt.aw_got = 1'b0;
            st_nxt.w_got = 1'b0;
            st_nxt.bvalid = 1'b1;
            unique case (bus_wr_addr)
                OFF_LOW, OFF_LATCH, OFF_PTR, OFF_BANK, OFF_PC: st_nxt.bresp = RESP_OKAY;
                default: st_nxt.bresp = RESP_SLVERR;
            endcase
        end
        // The response stands until the master takes it.
        if (st_r.bvalid && bready)
        begin
            st_nxt.bvalid = 1'b0;
        end

        // Read channel.
        // No stack status is ever reported.
        if (arvalid && arready)
        begin
            st_nxt.rvalid = 1'b1;
            st_nxt.rresp = RESP_OKAY;
            st_nxt.rdata = 32'h00000000;
            unique case ({araddr[7:2], 2'b00})
                OFF_LOW: st_nxt.rdata = {24'h000000, st_r.pc[7:0]};
                OFF_LATCH: st_nxt.rdata = {27'h0000000, st_r.latch};
                OFF_PTR: st_nxt.rdata = {24'h000000, st_r.ptr};
                OFF_BANK: st_nxt.rdata = {31'h00000000, bank_pointer_bit};
                // Full counter is read-only; its high bits still cannot be written.
                OFF_PC: st_nxt.rdata = {19'h00000, st_r.pc};
                default: st_nxt.rresp = RESP_SLVERR;
            endcase
        end
        else if (st_r.rvalid && rready)
        begin
            st_nxt.rvalid = 1'b0;
        end
    end

    // State register.
    // Reset clears the counter.
    // The bus channels, pointer and latch clear with it, so no half-taken
    // write survives a reset.
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            st_r <= '0;
        end
        else
        begin
            st_r <= st_nxt;
        end
    end

endmodule : pcs_program_counter

// File: pcs_data_mem.sv
// Data memory model that answers the indirect data port.
module pcs_data_mem
(
    input wire logic aclk,
    input wire logic [8:0] mem_addr,
    input wire logic mem_we,
    input wire logic [7:0] mem_wdata,
    output logic [7:0] mem_rdata
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] mem [512];
    // Each byte starts as its own low address, so a lost write is visible.
    initial
    begin
        for (int i = 0; i < 512; i++) mem[i] = i[7:0];
    end
    // real storage
    // One byte is stored per enabled edge; reads answer in the same cycle.
    always @(posedge aclk)
    begin
        if (mem_we) mem[mem_addr] <= mem_wdata;
    end
    assign mem_rdata = mem[mem_addr];
endmodule : pcs_data_mem

// File: pcs_chk.sv
// Checker for the program counter, return stack and indirect addressing.
module pcs_chk
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic step,
    input wire logic low_write,
    input wire logic [7:0] low_wdata,
    input wire logic latch_write,
    input wire logic jump,
    input wire logic call,
    input wire logic [10:0] jump_target,
    input wire logic irq_branch,
    input wire logic [12:0] irq_vector,
    input wire logic ret,
    input wire logic bank_pointer_bit,
    input wire logic ind_rd,
    input wire logic ind_wr,
    input wire logic [8:0] mem_addr,
    input wire logic mem_we,
    input wire logic [7:0] ind_rdata,
    input wire logic [12:0] pc,
    input wire logic [4:0] program_counter_high_latch,
    input wire logic [7:0] indirect_pointer,
    input wire logic bvalid
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);
    ////////////////////////////////////////
    chk_low_load: assert property (
        low_write && !(irq_branch || ret || call || jump) |=>
        pc == {$past(program_counter_high_latch), $past(low_wdata)}) else $error("low load");
    chk_jump_load: assert property (
        (jump || call) && !(irq_branch || ret) |=>
        pc == {$past(program_counter_high_latch[4:3]), $past(jump_target)}) else $error("jump");
    chk_irq_vector: assert property (
        irq_branch |=> pc == $past(irq_vector)) else $error("vector");
    chk_step_inc: assert property (
        step && !(low_write || jump || call || irq_branch || ret) |=>
        pc == $past(pc) + 13'h0001 || $rose(bvalid)) else $error("step");
    chk_latch_hold: assert property (
        (call || ret || irq_branch) && !latch_write |=>
        $stable(program_counter_high_latch) || $rose(bvalid)) else $error("latch moved");
    chk_addr_join: assert property (
        mem_addr == {bank_pointer_bit, indirect_pointer}) else $error("address");
    chk_self_write: assert property (
        ind_wr && indirect_pointer[6:0] == 7'h00 |-> !mem_we) else $error("self write");
    chk_self_read: assert property (
        ind_rd && indirect_pointer[6:0] == 7'h00 |=> ind_rdata == 8'h00) else $error("self read");
    cover property (call ##1 !call ##1 call);
    cover property (ret ##2 ret);
    cover property (ind_wr && mem_we);
    cover property (irq_branch ##2 ret);
endmodule : pcs_chk
bind pcs_program_counter pcs_chk chk_i (.*);

// File: tb_program_counter_stack_indirect.sv
// Self-checking testbench for the program counter, return stack and indirect addressing.
module tb_program_counter_stack_indirect
    import pcs_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic aclk = 1'b0, aresetn = 1'b0, bank_pointer_bit = 1'b0, mem_we;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic awready, wready, bvalid, arready, rvalid;
    logic step, low_write, latch_write, jump, call, irq_branch, ret, ptr_write, ind_rd, ind_wr;
    logic [9:0] kick = '0;
    logic [12:0] val = '0, irq_vector, pc;
    logic [7:0] low_wdata, ptr_wdata, ind_wdata, awaddr = '0, araddr = '0;
    logic [7:0] mem_rdata, mem_wdata, ind_rdata, indirect_pointer;
    logic [4:0] latch_wdata, program_counter_high_latch;
    logic [10:0] jump_target;
    logic [8:0] mem_addr;
    logic [31:0] wdata = '0, rdata, r;
    logic [3:0] wstrb = 4'hF;
    logic [1:0] bresp, rresp, s;
    int err_count = 0, samples_checked = 0;
    // One strobe bit per core request, one shared value for all data fields.
    assign {ind_wr, ind_rd, ptr_write, ret, irq_branch, call, jump, latch_write} = kick[9:2];
    assign {low_write, step} = kick[1:0];
    assign {low_wdata, ptr_wdata, ind_wdata} = {3{val[7:0]}};
    assign latch_wdata = val[4:0];
    assign jump_target = val[10:0];
    assign irq_vector = val;
    // Free-running core clock.
    always #2.5 aclk = ~aclk;
    pcs_program_counter uut (.*);
    pcs_data_mem mem_i (.*);
    ////////////////////////////////////////
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        samples_checked++;
        if (g !== e)
        begin
            err_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask : chk
    // Raises request k for exactly one edge, then lets the result settle.
    task automatic op(input int k, input logic [12:0] v);
        @(posedge aclk);
        kick[k] <= 1'b1;
        val <= v;
        @(posedge aclk);
        kick <= '0;
        #1;
    endtask : op
    // One bus transfer; holds each channel until its handshake edge.
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        logic ga, gw, ta, gr;
        int n;
        ga = !w;
        gw = !w;
        gr = 1'b0;
        n = 0;
        @(posedge aclk);
        awaddr <= a;
        araddr <= a;
        wdata <= d;
        awvalid <= w;
        wvalid <= w;
        bready <= w;
        arvalid <= !w;
        rready <= !w;
        while (!gr && n < 64)
        begin
            @(negedge aclk);
            ga = ga | awready;
            gw = gw | wready;
            ta = arready;
            gr = w ? bvalid : rvalid;
            r = rdata;
            s = w ? bresp : rresp;
            n++;
            @(posedge aclk);
            if (ga) awvalid <= 1'b0;
            if (gw) wvalid <= 1'b0;
            if (ta) arvalid <= 1'b0;
        end
        bready <= 1'b0;
        rready <= 1'b0;
        #1;
        if (!gr)
        begin
            err_count++;
            final_report();
        end
    endtask : bus
    task automatic final_report();
        $display("checks %0d mismatches %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : final_report
    ////////////////////////////////////////
    // Main sequence: reset, loads, stack, indirect port, bus corners.
    initial
    begin
        repeat (16) @(posedge aclk);
        aresetn <= 1'b1;
        #1;
        chk(pc, 32'h0);
        bus(1'b0, OFF_PC, 32'h0);
        chk(r, 32'h0);
        op(2, 13'h0015);
        op(1, 13'h00A7);
        chk(pc, 32'h15A7);
        bus(1'b0, OFF_LOW, 32'h0);
        chk(r, 32'hA7);
        bus(1'b1, OFF_LOW, 32'h3C);
        chk(pc, 32'h153C);
        op(0, 13'h0000);
        chk(pc, 32'h153D);
        op(3, 13'h07FF);
        chk(pc, 32'h17FF);
        op(2, 13'h0002);
        op(1, 13'h00FF);
        chk(pc, 32'h02FF);
        // Software carries the page itself before the low byte rolls over.
        op(2, 13'h0003);
        op(1, 13'h0000);
        chk(pc, 32'h0300);
        $display("test load done");
        op(2, 13'h0004);
        op(3, 13'h0000);
        for (int i = 0; i < 9; i++) op(4, 13'((i + 1) * 16));
        for (int k = 0; k < 9; k++)
        begin
            op(6, 13'h0000);
            chk(pc, (k < 8) ? 32'((8 - k) * 16 + 1) : 32'h81);
            chk(program_counter_high_latch, 32'h4);
        end
        op(5, 13'h0004);
        chk(pc, 32'h4);
        op(6, 13'h0000);
        chk(pc, 32'h81);
        $display("test stack done");
        @(posedge aclk);
        bank_pointer_bit <= 1'b1;
        op(7, 13'h0025);
        chk(mem_addr, 32'h125);
        chk(indirect_pointer, 32'h25);
        op(9, 13'h005A);
        chk(mem_i.mem[9'h125], 32'h5A);
        op(8, 13'h0000);
        chk(ind_rdata, 32'h5A);
        bus(1'b0, OFF_BANK, 32'h0);
        chk(r, 32'h1);
        bus(1'b1, OFF_PTR, 32'h80);
        op(9, 13'h00FF);
        chk(mem_i.mem[9'h180], 32'h80);
        op(8, 13'h0000);
        chk(ind_rdata, 32'h0);
        $display("test indirect done");
        bus(1'b0, 8'h20, 32'h0);
        chk(s, RESP_SLVERR);
        bus(1'b1, 8'h20, 32'h0);
        chk(s, RESP_SLVERR);
        bus(1'b1, OFF_PC, 32'h0);
        chk(pc, 32'h81);
        bus(1'b1, OFF_LATCH, 32'h1F);
        bus(1'b0, OFF_LATCH, 32'h0);
        chk(r, 32'h1F);
        chk(s, RESP_OKAY);
        // A write with lane zero disabled must leave the latch alone.
        @(posedge aclk);
        wstrb <= 4'h0;
        bus(1'b1, OFF_LATCH, 32'h3);
        chk(s, RESP_OKAY);
        @(posedge aclk);
        wstrb <= 4'hF;
        bus(1'b0, OFF_LATCH, 32'h0);
        chk(r, 32'h1F);
        $display("test bus done");
        // Reset in mid-run clears a counter that is away from zero.
        @(posedge aclk);
        aresetn <= 1'b0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        #1;
        chk(pc, 32'h0);
        op(0, 13'h0000);
        chk(pc, 32'h1);
        $display("test reset done");
        final_report();
    end
endmodule : tb_program_counter_stack_indirect
